//--- hdl/uart_iid_regs.svh
// register map, field positions, reset values and timing figures of the interrupt block
`ifndef UART_IID_REGS_SVH
`define UART_IID_REGS_SVH

// byte addresses on the peripheral bus
`define RXTX_ADDR 32'h4004_8000
`define IER_ADDR 32'h4004_8004
`define IID_ADDR 32'h4004_8008
`define LCR_ADDR 32'h4004_800c
`define LSR_ADDR 32'h4004_8014
`define ABC_ADDR 32'h4004_8020

// enable register fields
`define IER_RXLVL 0
`define IER_TXEMPTY 1
`define IER_RXLINE 2
`define IER_ABDONE 8
`define IER_ABTMO 9

// fifo control fields
`define FCR_FIFO_ON 0
`define FCR_TRIG_HI 7
`define FCR_TRIG_LO 6

// auto-baud control clear bits
`define ABC_CLR_DONE 8
`define ABC_CLR_TMO 9

// identification nibble {source code, pending_n}
`define IID_NONE 4'h1
`define IID_RXLINE 4'h6
`define IID_RXLVL 4'h4
`define IID_CHARTMO 4'hc
`define IID_TXEMPTY 4'h2

// reset values
`define IER_RESET 10'h000
`define FCR_RESET 8'h00
`define LCR_RESET 2'h3

// receive trigger levels in characters
`define TRIG_LVL0 5'h01
`define TRIG_LVL1 5'h04
`define TRIG_LVL2 5'h08
`define TRIG_LVL3 5'h0e

// sample clocks per bit, and time-out formula factors
`define SAMPLES_PER_BIT 16
`define TMO_WL_MUL 7
`define TMO_WL_SUB 2
`define TMO_SCALE 8
`define TMO_EXTRA 1

`endif

//--- hdl/uart_iid_pkg.sv
// types shared by the interrupt identification block
package uart_iid_pkg;
    typedef enum logic [1:0] {TX_LOADED, TX_WAIT, TX_IDLE} tx_empty_state_t;
    typedef logic [3:0] src_vec_t;
endpackage

//--- hdl/uart_char_timeout.sv
// character time-out counter for the receive fifo
`timescale 1ns/1ps
`default_nettype none
module uart_char_timeout #(
    parameter int LIMIT_W = 12
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sampleTick,
    input wire logic rxActivity,
    input wire logic rxHolding,
    input wire logic [LIMIT_W-1:0] limit,
    output logic timedOut
);
    logic [LIMIT_W-1:0] count;
    logic [LIMIT_W-1:0] next_count;
    logic next_timedOut;

    // the longest interval, eight-bit words at the top trigger level, needs ten bits
    if (LIMIT_W < 10) begin : g_width_check
        $error("limit width too narrow for the longest time-out");
    end

    always_comb begin
        next_count = count;
        next_timedOut = timedOut;
        if (rxActivity || !rxHolding) begin
            next_count = '0;
            next_timedOut = 1'b0;
        end else if (sampleTick && !timedOut) begin
            next_count = count + 1'b1;
            if (count + 1'b1 >= limit) begin
                next_timedOut = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            timedOut <= 1'b0;
        end else begin
            count <= next_count;
            timedOut <= next_timedOut;
        end
    end
endmodule // uart_char_timeout
`default_nettype wire

//--- hdl/uart_iid.sv
// interrupt identification and prioritisation with its apb register slave
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "uart_iid_regs.svh"
module uart_iid #(
    parameter int FIFO_DEPTH = 16,
    parameter int CNT_W = 5
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sampleTick,
    input wire logic [CNT_W-1:0] rxCount,
    input wire logic [7:0] rxData,
    input wire logic rxFifoWrite,
    input wire logic overrunErr,
    input wire logic parity_err,
    input wire logic framing_err,
    input wire logic break_seen,
    input wire logic [CNT_W-1:0] txCount,
    input wire logic autobaudDone,
    input wire logic autobaudTimeout,
    output logic rxBufferRead,
    output logic txWrite,
    output logic [7:0] txData,
    output logic fifo_on_ctrl,
    output logic [1:0] trigSel,
    output logic [1:0] wordLenSel,
    output logic uartIrq
);
    import uart_iid_pkg::*;

    // refused at elaboration so a bad size never reaches a netlist
    if (FIFO_DEPTH < 14 || (1 << CNT_W) <= FIFO_DEPTH) begin : g_size_check
        $error("fifo depth must reach 14 and fit the count width");
    end

    // ************************************************************
    // decoding helpers
    // ************************************************************
    // priority order line > level > time-out > tx empty
    function automatic logic [3:0] encodeIid(input src_vec_t s);
        if (s[3]) begin
            encodeIid = `IID_RXLINE;
        end else if (s[2]) begin
            encodeIid = `IID_RXLVL;
        end else if (s[1]) begin
            encodeIid = `IID_CHARTMO;
        end else if (s[0]) begin
            encodeIid = `IID_TXEMPTY;
        end else begin
            encodeIid = `IID_NONE;
        end
    endfunction

    function automatic logic [CNT_W-1:0] trigChars(input logic [1:0] sel);
        case (sel)
            2'h0: trigChars = CNT_W'(`TRIG_LVL0);
            2'h1: trigChars = CNT_W'(`TRIG_LVL1);
            2'h2: trigChars = CNT_W'(`TRIG_LVL2);
            default: trigChars = CNT_W'(`TRIG_LVL3);
        endcase
    endfunction

    // ************************************************************
    // bus decode
    // ************************************************************
    logic setupPhase;
    logic accessPhase;
    logic mapped;
    logic iidAccess;
    logic rdRxtx;
    logic rdIid;
    logic rdLsr;
    logic wrRxtx;
    logic wrIer;
    logic wrFcr;
    logic wrLcr;
    logic wrAbc;

    always_comb begin
        setupPhase = psel && !penable;
        accessPhase = psel && penable;
        if (paddr == `RXTX_ADDR || paddr == `IER_ADDR || paddr == `IID_ADDR) begin
            mapped = 1'b1;
        end else if (paddr == `LCR_ADDR || paddr == `LSR_ADDR || paddr == `ABC_ADDR) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
        iidAccess = psel && !pwrite && paddr == `IID_ADDR;
        rdRxtx = accessPhase && !pwrite && paddr == `RXTX_ADDR;
        rdIid = accessPhase && iidAccess;
        rdLsr = accessPhase && !pwrite && paddr == `LSR_ADDR;
        wrRxtx = accessPhase && pwrite && paddr == `RXTX_ADDR;
        wrIer = accessPhase && pwrite && paddr == `IER_ADDR;
        wrFcr = accessPhase && pwrite && paddr == `IID_ADDR;
        wrLcr = accessPhase && pwrite && paddr == `LCR_ADDR;
        wrAbc = accessPhase && pwrite && paddr == `ABC_ADDR;
        pready = 1'b1;
        pslverr = accessPhase && !mapped;
        rxBufferRead = rdRxtx;
    end

    // ************************************************************
    // control and status state
    // ************************************************************
    logic [9:0] ier;
    logic [7:0] fcr;
    logic [3:0] lineErr;
    logic abDone;
    logic abTmo;
    src_vec_t srcHeld;
    tx_empty_state_t txState;
    logic [7:0] txDelay;
    logic twoSeen;
    logic threPend;
    logic ctiFlag;
    logic [11:0] tmoLimit;
    logic [31:0] next_prdata;
    logic [9:0] next_ier;
    logic [7:0] next_fcr;
    logic [1:0] next_wordLenSel;
    logic [3:0] next_lineErr;
    logic next_abDone;
    logic next_abTmo;
    src_vec_t next_srcHeld;
    src_vec_t liveSrc;
    tx_empty_state_t next_txState;
    logic [7:0] next_txDelay;
    logic [7:0] txDelayLimit;
    logic next_twoSeen;
    logic next_threPend;
    logic threEvent;
    logic next_txWrite;
    logic [7:0] next_txData;
    logic next_uartIrq;
    logic [3:0] iidNow;
    logic [CNT_W-1:0] trigLvl;
    int tmoCalc;

    uart_char_timeout #(
        .LIMIT_W(12)
    ) u_tmo (
        .mclk(mclk),
        .rst_n(rst_n),
        .sampleTick(sampleTick),
        .rxActivity(rxFifoWrite || rdRxtx),
        .rxHolding(rxCount != '0),
        .limit(tmoLimit),
        .timedOut(ctiFlag)
    );

    always_comb begin
        trigLvl = trigChars(fcr[`FCR_TRIG_HI:`FCR_TRIG_LO]);
        // word length in bits is 5 plus the select
        tmoCalc = ((5 + int'(wordLenSel)) * `TMO_WL_MUL - `TMO_WL_SUB) * `TMO_SCALE
                + (int'(trigLvl) - int'(rxCount)) * `TMO_SCALE + `TMO_EXTRA;
        // more held than the trigger would shorten below one sample tick
        if (tmoCalc < 1) begin
            tmoCalc = 1;
        end
        tmoLimit = tmoCalc[11:0];
        txDelayLimit = 8'((6 + int'(wordLenSel)) * `SAMPLES_PER_BIT);
        liveSrc[3] = (lineErr != '0) && ier[`IER_RXLINE];
        liveSrc[2] = (rxCount >= trigLvl) && ier[`IER_RXLVL];
        liveSrc[1] = ctiFlag && ier[`IER_RXLVL];
        liveSrc[0] = threPend && ier[`IER_TXEMPTY];
        iidNow = encodeIid(srcHeld);
    end

    // ************************************************************
    // register and flag updates
    // ************************************************************
    always_comb begin
        next_ier = wrIer ? pwdata[9:0] : ier;
        next_fcr = wrFcr ? pwdata[7:0] : fcr;
        next_wordLenSel = wrLcr ? pwdata[1:0] : wordLenSel;
        next_txWrite = wrRxtx;
        next_txData = wrRxtx ? pwdata[7:0] : txData;
        // set wins over the read clear so no error is lost
        next_lineErr = (rdLsr ? 4'h0 : lineErr)
                     | {break_seen, framing_err, parity_err, overrunErr};
        next_abDone = (abDone && !(wrAbc && pwdata[`ABC_CLR_DONE])) || autobaudDone;
        next_abTmo = (abTmo && !(wrAbc && pwdata[`ABC_CLR_TMO])) || autobaudTimeout;
        next_srcHeld = iidAccess ? srcHeld : liveSrc;
        next_uartIrq = !iidNow[0]
                     || (abDone && ier[`IER_ABDONE])
                     || (abTmo && ier[`IER_ABTMO]);
        next_prdata = prdata;
        if (setupPhase && !pwrite) begin
            if (paddr == `RXTX_ADDR) begin
                next_prdata = {24'h0, rxData};
            end else if (paddr == `IER_ADDR) begin
                next_prdata = {22'h0, ier};
            end else if (paddr == `IID_ADDR) begin
                next_prdata = {22'h0,
                               abTmo && ier[`IER_ABTMO],
                               abDone && ier[`IER_ABDONE],
                               {2{fcr[`FCR_FIFO_ON]}},
                               2'b00, iidNow};
            end else if (paddr == `LCR_ADDR) begin
                next_prdata = {30'h0, wordLenSel};
            end else if (paddr == `LSR_ADDR) begin
                next_prdata = {26'h0, txCount == '0, lineErr, rxCount != '0};
            end else begin
                next_prdata = 32'h0;
            end
        end
    end

    // ************************************************************
    // transmit empty qualification
    // ************************************************************
    always_comb begin
        next_txState = txState;
        next_txDelay = txDelay;
        threEvent = 1'b0;
        case (txState)
            TX_LOADED: begin
                if (txCount == '0) begin
                    if (twoSeen) begin
                        threEvent = 1'b1;
                        next_txState = TX_IDLE;
                    end else begin
                        next_txState = TX_WAIT;
                        next_txDelay = 8'h00;
                    end
                end
            end
            TX_WAIT: begin
                if (txCount != '0) begin
                    next_txState = TX_LOADED;
                end else if (sampleTick) begin
                    next_txDelay = txDelay + 8'h01;
                    if (txDelay + 8'h01 >= txDelayLimit) begin
                        threEvent = 1'b1;
                        next_txState = TX_IDLE;
                    end
                end
            end
            default: begin
                if (txCount != '0) begin
                    next_txState = TX_LOADED;
                end
            end
        endcase
        next_twoSeen = threEvent ? 1'b0 : (twoSeen || txCount >= CNT_W'(2));
        // a new empty event wins over a clear in the same cycle
        next_threPend = (threPend && !wrRxtx && !(rdIid && iidNow == `IID_TXEMPTY))
                      || threEvent;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0;
            ier <= `IER_RESET;
            fcr <= `FCR_RESET;
            wordLenSel <= `LCR_RESET;
            lineErr <= 4'h0;
            abDone <= 1'b0;
            abTmo <= 1'b0;
            srcHeld <= 4'h0;
            txState <= TX_WAIT;
            txDelay <= 8'h00;
            twoSeen <= 1'b0;
            threPend <= 1'b0;
            txWrite <= 1'b0;
            txData <= 8'h00;
            uartIrq <= 1'b0;
        end else begin
            prdata <= next_prdata;
            ier <= next_ier;
            fcr <= next_fcr;
            wordLenSel <= next_wordLenSel;
            lineErr <= next_lineErr;
            abDone <= next_abDone;
            abTmo <= next_abTmo;
            srcHeld <= next_srcHeld;
            txState <= next_txState;
            txDelay <= next_txDelay;
            twoSeen <= next_twoSeen;
            threPend <= next_threPend;
            txWrite <= next_txWrite;
            txData <= next_txData;
            uartIrq <= next_uartIrq;
        end
    end

    assign fifo_on_ctrl = fcr[`FCR_FIFO_ON];
    assign trigSel = fcr[`FCR_TRIG_HI:`FCR_TRIG_LO];
endmodule // uart_iid
`default_nettype wire

//--- test/uart_iid_asserts.sv
// port assertions for the interrupt identification block
`timescale 1ns/1ps
`default_nettype none
`include "uart_iid_regs.svh"
module uart_iid_asserts (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic rxBufferRead,
    input wire logic txWrite,
    input wire logic [7:0] txData,
    input wire logic fifo_on_ctrl,
    input wire logic uartIrq
);
    // ********************************
    // bus phases seen at the ports
    // ********************************
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence iidRead;
        psel && penable && !pwrite && paddr == `IID_ADDR;
    endsequence
    sequence holdWrite;
        psel && penable && pwrite && paddr == `RXTX_ADDR;
    endsequence
    sequence ctrlWrite;
        psel && penable && pwrite && paddr == `IID_ADDR;
    endsequence
    mirror_bits_a: assert property (iidRead |-> prdata[7:6] == {2{fifo_on_ctrl}})
        else $error("fifo mirror bits wrong");
    idle_code_a: assert property (iidRead |-> prdata[0] == (prdata[3:1] == 3'h0))
        else $error("pending flag and code disagree");
    reserved_code_a: assert property (iidRead |-> !(prdata[3:1] inside {3'h4, 3'h5, 3'h7}))
        else $error("reserved source code reported");
    irq_level_a: assert property (iidRead |-> uartIrq == (!prdata[0] || (|prdata[9:8])))
        else $error("irq output disagrees with identity");
    rx_pop_a: assert property (rxBufferRead == (psel && penable && !pwrite && paddr == `RXTX_ADDR))
        else $error("receive pop without data read");
    tx_load_a: assert property (holdWrite |=> txWrite && txData == $past(pwdata[7:0]))
        else $error("holding write not passed on");
    tx_only_a: assert property (txWrite |-> $past(psel && penable && pwrite && paddr == `RXTX_ADDR))
        else $error("spurious holding write");
    fifo_ctrl_a: assert property (ctrlWrite |=> fifo_on_ctrl == $past(pwdata[0]))
        else $error("fifo enable not stored");
endmodule // uart_iid_asserts
bind uart_iid uart_iid_asserts u_uart_iid_asserts (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .rxBufferRead(rxBufferRead), .txWrite(txWrite), .txData(txData),
    .fifo_on_ctrl(fifo_on_ctrl), .uartIrq(uartIrq));
`default_nettype wire

//--- test/tb.sv
// self-checking bench for the interrupt identification block
`timescale 1ns/1ps
`default_nettype none
`include "uart_iid_regs.svh"
module tb;
    import uart_iid_pkg::*;
    logic mclk, rst_n, psel, penable, pwrite, sampleTick, rxFifoWrite, errBit;
    logic pready, pslverr, rxBufferRead, txWrite, fifo_on_ctrl, uartIrq;
    logic [31:0] paddr, pwdata, prdata, rdv;
    logic [7:0] rxData, txData;
    logic [4:0] rxCount, txCount;
    logic [3:0] errV;
    logic [1:0] abV, trigSel, wordLenSel;
    int fails, totalChecks;
    uart_iid u_uart_iid (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sampleTick(sampleTick), .rxCount(rxCount), .rxData(rxData),
        .rxFifoWrite(rxFifoWrite), .overrunErr(errV[0]), .parity_err(errV[1]),
        .framing_err(errV[2]), .break_seen(errV[3]), .txCount(txCount),
        .autobaudDone(abV[0]), .autobaudTimeout(abV[1]), .rxBufferRead(rxBufferRead),
        .txWrite(txWrite), .txData(txData), .fifo_on_ctrl(fifo_on_ctrl), .trigSel(trigSel),
        .wordLenSel(wordLenSel), .uartIrq(uartIrq));
    always #20 mclk = ~mclk;
    // ********************************
    // bus tasks and comparison
    // ********************************
    task conclude;
        $display("checks %0d mismatches %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one idle cycle after each transfer keeps every signal to one update per edge
    task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
        int n;
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= addr; pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdv = prdata;
        errBit = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            $display("BAD %0t no ready from the slave", $time);
            fails++;
            conclude();
        end else begin
            @(posedge mclk);
        end
    endtask
    task automatic rd(input logic [31:0] addr, input logic [31:0] exp);
        xfer(1'b0, addr, 32'h0);
        chk(rdv, exp);
        chk({31'h0, errBit}, {31'h0, addr == 32'h4004_8030});
    endtask
    task automatic wr(input logic [31:0] addr, input logic [31:0] d);
        xfer(1'b1, addr, d);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // ********************************
    // scenarios
    // ********************************
    initial begin
        repeat (20000) @(posedge mclk);
        $display("BAD %0t run did not finish", $time);
        fails++;
        conclude();
    end
    initial begin
        mclk = 0; rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        sampleTick = 0; rxFifoWrite = 0; rxData = 8'ha5; rxCount = 0; txCount = 0;
        errV = 0; abV = 0; fails = 0; totalChecks = 0;
        tick(3);
        rst_n <= 1'b1;
        tick(1);
        rd(`IID_ADDR, 32'h1);
        rd(`LCR_ADDR, 32'h3);
        chk({30'h0, wordLenSel}, 32'h3);
        rd(32'h4004_8030, 32'h0);
        wr(`IID_ADDR, 32'h1);
        rd(`IID_ADDR, 32'hc1);
        wr(`IER_ADDR, 32'h7);
        rd(`IER_ADDR, 32'h7);
        rxCount <= 5'h01;
        tick(2);
        rd(`IID_ADDR, 32'hc4);
        for (int i = 0; i < 4; i++) begin
            errV[i] <= 1'b1;
            tick(1);
            errV <= 4'h0;
            tick(2);
            rd(`IID_ADDR, 32'hc6);
            rd(`LSR_ADDR, 32'h21 | (32'h1 << (i + 1)));
            rd(`IID_ADDR, 32'hc4);
        end
        wr(`IID_ADDR, 32'h41);
        chk({30'h0, trigSel}, 32'h1);
        rxCount <= 5'h03;
        tick(2);
        rd(`IID_ADDR, 32'hc1);
        rxCount <= 5'h04;
        tick(2);
        rd(`IID_ADDR, 32'hc4);
        rxCount <= 5'h03;
        rd(`RXTX_ADDR, 32'ha5);
        // limit is (8*7-2)*8+(4-3)*8+1 = 441 ticks; tx empty delay 144 ticks passes first
        sampleTick <= 1'b1;
        tick(430);
        rd(`IID_ADDR, 32'hc2);
        tick(20);
        rd(`IID_ADDR, 32'hcc);
        rxFifoWrite <= 1'b1;
        sampleTick <= 1'b0;
        tick(1);
        rxFifoWrite <= 1'b0;
        tick(2);
        rd(`IID_ADDR, 32'hc1);
        chk({31'h0, uartIrq}, 32'h0);
        wr(`IER_ADDR, 32'h6);
        rxCount <= 5'h04;
        tick(2);
        rd(`IID_ADDR, 32'hc1);
        for (int k = 0; k < 2; k++) begin
            txCount <= 5'h02;
            tick(2);
            txCount <= 5'h00;
            // empty event, then held source, then the registered irq: three edges
            tick(4);
            chk({31'h0, uartIrq}, 32'h1);
            if (k == 0)
                rd(`IID_ADDR, 32'hc2);
            else
                wr(`RXTX_ADDR, 32'h5a);
            rd(`IID_ADDR, 32'hc1);
        end
        chk({24'h0, txData}, 32'h5a);
        wr(`IER_ADDR, 32'h304);
        fork
            rd(`IID_ADDR, 32'hc1);
            begin tick(1); errV[0] <= 1'b1; tick(1); errV[0] <= 1'b0; end
        join
        tick(2);
        rd(`IID_ADDR, 32'hc6);
        rd(`LSR_ADDR, 32'h23);
        for (int j = 0; j < 2; j++) begin
            abV[j] <= 1'b1;
            tick(1);
            abV <= 2'h0;
            tick(2);
            rd(`IID_ADDR, 32'hc1 | (32'h100 << j));
            chk({31'h0, uartIrq}, 32'h1);
            rd(`IID_ADDR, 32'hc1 | (32'h100 << j));
            wr(`ABC_ADDR, 32'h100 << j);
            tick(1);
            rd(`IID_ADDR, 32'hc1);
        end
        conclude();
    end
endmodule // tb
`default_nettype wire
